// ===== rbac_bod.v
// brownout comparators: four reset levels and three interrupt levels
// assumes the supply arrives as an unsigned digitised code
`timescale 1ns/100ps
`include "rbac_defs.vh"
module rbac_bod (
   input  wire       clk_sys,     // system clock
   input  wire       rst_n,       // power-on reset, active low
   input  wire [7:0] vdd_code,    // supply code
   input  wire [1:0] irq_sel,     // interrupt level, 0 is off
   input  wire [1:0] rst_sel,     // reset level
   input  wire       rst_en,      // forced reset enable
   output wire       irq_out,     // below interrupt level
   output wire       rst_req      // forced reset request
);
   reg irq_reg;
   reg rst_req_reg;

   function [7:0] rst_thr;
      input [1:0] sel;
      case (sel)
         2'h0:    rst_thr = `RBAC_BOD_RST_LVL0;
         2'h1:    rst_thr = `RBAC_BOD_RST_LVL1;
         2'h2:    rst_thr = `RBAC_BOD_RST_LVL2;
         default: rst_thr = `RBAC_BOD_RST_LVL3;
      endcase
   endfunction

   function [7:0] irq_thr;
      input [1:0] sel;
      case (sel)
         2'h0:    irq_thr = `RBAC_BOD_IRQ_LVL0;
         2'h1:    irq_thr = `RBAC_BOD_IRQ_LVL1;
         2'h2:    irq_thr = `RBAC_BOD_IRQ_LVL2;
         default: irq_thr = `RBAC_BOD_IRQ_LVL3;
      endcase
   endfunction

   always @(posedge clk_sys) begin
      if (!rst_n) begin
         irq_reg     <= 1'b0;
         rst_req_reg <= 1'b0;
      end else begin
         irq_reg     <= vdd_code < irq_thr(irq_sel);
         rst_req_reg <= rst_en & (vdd_code < rst_thr(rst_sel));
      end
   end

   assign irq_out = irq_reg;
   assign rst_req = rst_req_reg;
endmodule

// ===== rbac_defs.vh
// constants for the reset, brownout and access control block
// assumes a 20 MHz system clock and an 8-bit digitised supply code
`ifndef RBAC_DEFS_VH
`define RBAC_DEFS_VH
`define RBAC_CLK_NS        50
`define RBAC_PIN_PULSE_NS  50
`define RBAC_PIN_MIN_CYC   ((`RBAC_PIN_PULSE_NS + `RBAC_CLK_NS - 1) / `RBAC_CLK_NS)
`define RBAC_HOLD_CYC      4'h8
`define RBAC_RESET_VECTOR  32'h0000_0000
// sequencer states
`define RBAC_ST_WAIT_VDD   3'h0
`define RBAC_ST_FRO        3'h1
`define RBAC_ST_FLASH      3'h2
`define RBAC_ST_HOLD       3'h3
`define RBAC_ST_RUN        3'h4
// clock sources
`define RBAC_CLK_FRO       2'h0
`define RBAC_CLK_LOW_POWER_OSC     2'h1
`define RBAC_CLK_EXT       2'h2
// brownout thresholds, supply codes
`define RBAC_BOD_RST_LVL0  8'h50
`define RBAC_BOD_RST_LVL1  8'h58
`define RBAC_BOD_RST_LVL2  8'h60
`define RBAC_BOD_RST_LVL3  8'h68
`define RBAC_BOD_IRQ_LVL0  8'h00
`define RBAC_BOD_IRQ_LVL1  8'h70
`define RBAC_BOD_IRQ_LVL2  8'h78
`define RBAC_BOD_IRQ_LVL3  8'h80
// protection word patterns
`define RBAC_PROT_PAT_NOPIN 32'h4e69_5350
`define RBAC_PROT_PAT_ONE   32'h1234_5678
`define RBAC_PROT_PAT_TWO   32'h8765_4321
`define RBAC_PROT_PAT_THREE 32'h4321_8765
// protection levels
`define RBAC_LVL_NONE      2'h0
`define RBAC_LVL_ONE       2'h1
`define RBAC_LVL_TWO       2'h2
`define RBAC_LVL_THREE     2'h3
// programming command classes
`define RBAC_CMD_READ      3'h0
`define RBAC_CMD_WRITE     3'h1
`define RBAC_CMD_ERASE_SEC 3'h2
`define RBAC_CMD_ERASE_ALL 3'h3
`define RBAC_CMD_GO        3'h4
`define RBAC_CMD_INFO      3'h5
// debug resources
`define RBAC_NUM_BKPT      3'h4
`define RBAC_NUM_WATCH     2'h2
`endif

// ===== rbac_ext_model.sv
// external party: oscillator and flash readiness, and the reset pin driver
// assumes the block raises fro_en and flash_init_req as levels
`timescale 1ns/100ps
module rbac_ext_model (
   input  logic clk_sys,                // clock
   input  logic rst_n,                  // reset
   input  logic slow,                   // answer late
   input  logic pin_low,                // pull pin low
   input  logic fro_en,                 // osc enable
   input  logic flash_init_req,         // flash init
   output logic fro_ready = 1'b0,       // osc running
   output logic flash_init_done = 1'b0, // flash ready
   output logic reset_pin_in = 1'b1     // pin level
);
   logic [3:0] osc_cnt_reg = 4'h0;
   logic [3:0] fl_cnt_reg  = 4'h0;
   wire  [3:0] lim = slow ? 4'h6 : 4'h1;
   always @(posedge clk_sys) begin
      fro_ready <= rst_n && fro_en && osc_cnt_reg >= lim;
      osc_cnt_reg <= (rst_n && fro_en) ? osc_cnt_reg + {3'h0, !fro_ready} : 4'h0;
      flash_init_done <= flash_init_req && fl_cnt_reg >= lim;
      fl_cnt_reg <= flash_init_req ? fl_cnt_reg + {3'h0, !flash_init_done} : 4'h0;
      reset_pin_in <= ~pin_low;
   end
endmodule

// ===== rbac_sync2.v
// two-stage level synchroniser
// assumes one clock and synchronous active-low reset
`timescale 1ns/100ps
module rbac_sync2 #(
   parameter RST_VAL = 1'b1
) (
   input  wire clk_sys,   // system clock
   input  wire rst_n,     // reset, active low
   input  wire d_in,      // level to carry over
   output wire q_out      // synchronised level
);
   reg stage1_reg;
   reg stage2_reg;

   always @(posedge clk_sys) begin
      if (!rst_n) begin
         stage1_reg <= RST_VAL;
         stage2_reg <= RST_VAL;
      end else begin
         stage1_reg <= d_in;
         stage2_reg <= stage1_reg;
      end
   end

   assign q_out = stage2_reg;
endmodule

// ===== rbac_top.v
// reset sequencing, brownout and access control of a small controller
// assumes supply, oscillator and flash report readiness as levels
`timescale 1ns/100ps
`include "rbac_defs.vh"
module rbac_top (
   input  wire        clk_sys,          // system clock
   input  wire        rst_n,            // power-on reset, active low
   input  wire        reset_pin_in,     // external reset pin level
   input  wire        wdt_rst_req,      // watchdog reset request
   input  wire        vdd_usable,       // supply reached usable level
   input  wire [7:0]  vdd_code,         // digitised supply
   input  wire        fro_ready,        // oscillator running
   input  wire        flash_init_done,  // flash controller ready
   input  wire [31:0] prot_word_in,     // flash protection word
   input  wire        low_power_osc_ready,      // low-power oscillator stable
   input  wire        ext_clk_ready,    // external clock stable
   input  wire        clk_sel_we,       // software clock select write
   input  wire [1:0]  clk_sel_wdata,    // requested clock source
   input  wire        bod_cfg_we,       // brownout settings write
   input  wire [1:0]  bod_irq_sel_in,   // interrupt level select
   input  wire [1:0]  bod_rst_sel_in,   // reset level select
   input  wire        bod_rst_en_in,    // forced reset enable
   input  wire        isp_pin_req,      // programming entry pin asserted
   input  wire        isp_cmd_valid,    // programming command offered
   input  wire [2:0]  isp_cmd_class,    // programming command class
   input  wire [4:0]  isp_sector,       // sector addressed by command
   input  wire        iap_cmd_valid,    // firmware programming command
   input  wire [3:0]  dbg_bkpt_req,     // breakpoints asked for
   input  wire [1:0]  dbg_watch_req,    // watchpoints asked for
   output wire        chip_rst_n,       // chip reset, active low
   output wire        fro_en,           // oscillator enable
   output wire        flash_init_req,   // flash initialise request
   output wire [31:0] cpu_fetch_addr,   // first fetch address
   output wire        cpu_start,        // one-cycle start pulse
   output wire [1:0]  clk_src_sel,      // active clock source
   output wire        bod_irq,          // interrupt to controller
   output wire        bod_status,       // polled brownout status
   output wire [1:0]  bod_irq_sel,      // current interrupt level
   output wire [1:0]  bod_rst_sel,      // current reset level
   output wire        bod_rst_en,       // current forced reset enable
   output wire [1:0]  prot_level,       // active protection level
   output wire        isp_pin_dis,      // pin entry disabled
   output wire        isp_enter,        // enter programming via pin
   output wire        isp_cmd_grant,    // programming command allowed
   output wire        iap_cmd_grant,    // firmware command allowed
   output wire        swd_en,           // two-wire debug enabled
   output wire        jtag_bscan_en,    // boundary scan mode
   output wire        jtag_pin_route,   // scan functions on pins
   output wire        jtag_cpu_dbg,     // scan port debug path
   output wire [3:0]  dbg_bkpt_en,      // breakpoints granted
   output wire [1:0]  dbg_watch_en,     // watchpoints granted
   output wire        rst_cause_pin,    // last reset from pin
   output wire        rst_cause_wdt,    // last reset from watchdog
   output wire        rst_cause_bod     // last reset from brownout
);
   reg  [2:0]  state_reg;
   reg  [2:0]  state_next;
   reg  [3:0]  hold_cnt_reg;
   reg  [3:0]  hold_cnt_next;
   reg  [2:0]  pin_low_cnt_reg;
   reg         fro_en_reg;
   reg         start_reg;
   reg  [31:0] fetch_addr_reg;
   reg  [1:0]  clk_src_reg;
   reg  [1:0]  bod_irq_sel_reg;
   reg  [1:0]  bod_rst_sel_reg;
   reg         bod_rst_en_reg;
   reg  [1:0]  prot_level_reg;
   reg         isp_pin_dis_reg;
   reg         cause_pin_reg;
   reg         cause_wdt_reg;
   reg         cause_bod_reg;
   reg  [3:0]  bkpt_en_reg;
   reg  [1:0]  watch_en_reg;
   reg         cmd_ok;
   wire        pin_sync;
   wire        pin_req;
   wire        bod_rst_req;
   wire        bod_irq_w;
   wire        any_req;
   wire        in_run;
   wire        clk_req_ok;

   localparam [31:0] PIN_MIN_CYC = `RBAC_PIN_MIN_CYC;

   // protection pattern to level
   function [1:0] prot_decode;
      input [31:0] word;
      case (word)
         `RBAC_PROT_PAT_ONE:   prot_decode = `RBAC_LVL_ONE;
         `RBAC_PROT_PAT_TWO:   prot_decode = `RBAC_LVL_TWO;
         `RBAC_PROT_PAT_THREE: prot_decode = `RBAC_LVL_THREE;
         default:              prot_decode = `RBAC_LVL_NONE;
      endcase
   endfunction

   rbac_sync2 #(
      .RST_VAL (1'b1)
   ) u_pin_sync (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .d_in    (reset_pin_in),
      .q_out   (pin_sync)
   );

   rbac_bod u_bod (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .vdd_code (vdd_code),
      .irq_sel  (bod_irq_sel_reg),
      .rst_sel  (bod_rst_sel_reg),
      .rst_en   (bod_rst_en_reg),
      .irq_out  (bod_irq_w),
      .rst_req  (bod_rst_req)
   );

   always @(posedge clk_sys) begin
      if (!rst_n) begin
         pin_low_cnt_reg <= 3'h0;
      end else if (pin_sync) begin
         pin_low_cnt_reg <= 3'h0;
      end else if (pin_low_cnt_reg != 3'h7) begin
         pin_low_cnt_reg <= pin_low_cnt_reg + 3'h1;
      end
   end

   assign pin_req = ({29'h0, pin_low_cnt_reg} >= PIN_MIN_CYC) | ~pin_sync;

   assign any_req = pin_req | wdt_rst_req | bod_rst_req;
   assign in_run  = (state_reg == `RBAC_ST_RUN);

   assign chip_rst_n = in_run & ~any_req & reset_pin_in;

   always @* begin
      state_next    = state_reg;
      hold_cnt_next = hold_cnt_reg;
      case (state_reg)
         `RBAC_ST_WAIT_VDD: begin
            if (vdd_usable && !any_req) begin
               state_next = `RBAC_ST_FRO;
            end
         end
         `RBAC_ST_FRO: begin
            if (fro_ready) begin
               state_next = `RBAC_ST_FLASH;
            end
         end
         `RBAC_ST_FLASH: begin
            if (flash_init_done) begin
               state_next    = `RBAC_ST_HOLD;
               hold_cnt_next = 4'h0;
            end
         end
         `RBAC_ST_HOLD: begin
            hold_cnt_next = hold_cnt_reg + 4'h1;
            if (hold_cnt_reg == `RBAC_HOLD_CYC - 4'h1) begin
               state_next = `RBAC_ST_RUN;
            end
         end
         `RBAC_ST_RUN: begin
            state_next = `RBAC_ST_RUN;
         end
         default: begin
            state_next = `RBAC_ST_WAIT_VDD;
         end
      endcase
      if (any_req || !vdd_usable) begin
         state_next = `RBAC_ST_WAIT_VDD;
      end
   end

   always @(posedge clk_sys) begin
      if (!rst_n) begin
         state_reg    <= `RBAC_ST_WAIT_VDD;
         hold_cnt_reg <= 4'h0;
      end else begin
         state_reg    <= state_next;
         hold_cnt_reg <= hold_cnt_next;
      end
   end

   always @(posedge clk_sys) begin
      if (!rst_n) begin
         fro_en_reg <= 1'b0;
      end else if (state_reg == `RBAC_ST_FRO) begin
         fro_en_reg <= 1'b1;
      end
   end

   assign flash_init_req = (state_reg == `RBAC_ST_FLASH);

   always @(posedge clk_sys) begin
      if (!rst_n) begin
         start_reg      <= 1'b0;
         fetch_addr_reg <= `RBAC_RESET_VECTOR;
      end else begin
         start_reg      <= (state_reg == `RBAC_ST_HOLD) &&
                           (state_next == `RBAC_ST_RUN);
         fetch_addr_reg <= `RBAC_RESET_VECTOR;
      end
   end

   assign clk_req_ok = (clk_sel_wdata == `RBAC_CLK_FRO) ||
                       ((clk_sel_wdata == `RBAC_CLK_LOW_POWER_OSC) && low_power_osc_ready) ||
                       ((clk_sel_wdata == `RBAC_CLK_EXT) && ext_clk_ready);

   always @(posedge clk_sys) begin
      if (!rst_n || !in_run) begin
         clk_src_reg <= `RBAC_CLK_FRO;
      end else if (clk_sel_we && clk_req_ok) begin
         clk_src_reg <= clk_sel_wdata;
      end
   end

   always @(posedge clk_sys) begin
      if (!rst_n) begin
         bod_irq_sel_reg <= 2'h0;
         bod_rst_sel_reg <= 2'h0;
         bod_rst_en_reg  <= 1'b0;
      end else if (bod_cfg_we) begin
         bod_irq_sel_reg <= bod_irq_sel_in;
         bod_rst_sel_reg <= bod_rst_sel_in;
         bod_rst_en_reg  <= bod_rst_en_in;
      end
   end

   // reset cause flags, set on request, cleared by power-on or by a request from another source
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         cause_pin_reg <= 1'b0;
         cause_wdt_reg <= 1'b0;
         cause_bod_reg <= 1'b0;
      end else begin
         cause_pin_reg <= pin_req | (cause_pin_reg & ~(wdt_rst_req | bod_rst_req));
         cause_wdt_reg <= wdt_rst_req | (cause_wdt_reg & ~(pin_req | bod_rst_req));
         cause_bod_reg <= bod_rst_req | (cause_bod_reg & ~(pin_req | wdt_rst_req));
      end
   end

   always @(posedge clk_sys) begin
      if (!rst_n) begin
         prot_level_reg  <= `RBAC_LVL_NONE;
         isp_pin_dis_reg <= 1'b0;
      end else if (flash_init_req && flash_init_done) begin
         prot_level_reg  <= prot_decode(prot_word_in);
         isp_pin_dis_reg <= (prot_word_in == `RBAC_PROT_PAT_NOPIN);
      end
   end

   assign isp_enter = isp_pin_req & ~isp_pin_dis_reg &
                      (prot_level_reg != `RBAC_LVL_THREE);

   // programming command filter per level
   always @* begin
      cmd_ok = 1'b0;
      case (prot_level_reg)
         `RBAC_LVL_NONE: begin
            cmd_ok = 1'b1;
         end
         `RBAC_LVL_ONE: begin
            case (isp_cmd_class)
               `RBAC_CMD_WRITE:     cmd_ok = (isp_sector != 5'h00);
               `RBAC_CMD_ERASE_SEC: cmd_ok = (isp_sector != 5'h00);
               `RBAC_CMD_GO:        cmd_ok = 1'b1;
               `RBAC_CMD_INFO:      cmd_ok = 1'b1;
               default:             cmd_ok = 1'b0;
            endcase
         end
         `RBAC_LVL_TWO: begin
            case (isp_cmd_class)
               `RBAC_CMD_ERASE_ALL: cmd_ok = 1'b1;
               `RBAC_CMD_WRITE:     cmd_ok = 1'b1;
               `RBAC_CMD_INFO:      cmd_ok = 1'b1;
               default:             cmd_ok = 1'b0;
            endcase
         end
         default: begin
            cmd_ok = 1'b0;
         end
      endcase
   end

   assign isp_cmd_grant = isp_cmd_valid & cmd_ok & in_run;

   assign iap_cmd_grant = iap_cmd_valid & in_run;

   assign jtag_bscan_en  = ~pin_sync;
   assign jtag_pin_route = ~pin_sync;

   assign swd_en = chip_rst_n & pin_sync & (prot_level_reg == `RBAC_LVL_NONE);

   assign jtag_cpu_dbg = 1'b0;

   always @(posedge clk_sys) begin
      if (!rst_n || !swd_en) begin
         bkpt_en_reg  <= 4'h0;
         watch_en_reg <= 2'h0;
      end else begin
         bkpt_en_reg  <= dbg_bkpt_req;
         watch_en_reg <= dbg_watch_req;
      end
   end

   assign fro_en         = fro_en_reg;
   assign cpu_fetch_addr = fetch_addr_reg;
   assign cpu_start      = start_reg;
   assign clk_src_sel    = clk_src_reg;
   assign bod_status     = bod_irq_w;
   assign bod_irq        = bod_irq_w;
   assign bod_irq_sel    = bod_irq_sel_reg;
   assign bod_rst_sel    = bod_rst_sel_reg;
   assign bod_rst_en     = bod_rst_en_reg;
   assign prot_level     = prot_level_reg;
   assign isp_pin_dis    = isp_pin_dis_reg;
   assign dbg_bkpt_en    = bkpt_en_reg;
   assign dbg_watch_en   = watch_en_reg;
   assign rst_cause_pin  = cause_pin_reg;
   assign rst_cause_wdt  = cause_wdt_reg;
   assign rst_cause_bod  = cause_bod_reg;
endmodule

// ===== rbac_top_properties.sv
// assertions on the ports of the reset, brownout and access control block
// assumes one clock and the synchronous active-low power-on reset
`timescale 1ns/100ps
`include "rbac_defs.vh"
module rbac_top_chk (
   input wire        clk_sys,        // clock
   input wire        rst_n,          // reset
   input wire        reset_pin_in,   // pin
   input wire        wdt_rst_req,    // watchdog
   input wire [7:0]  vdd_code,       // supply
   input wire        bod_cfg_we,     // cfg write
   input wire [1:0]  bod_irq_sel_in, // new level
   input wire        bod_rst_en_in,  // new enable
   input wire        iap_cmd_valid,  // fw command
   input wire        chip_rst_n,     // chip reset
   input wire [31:0] cpu_fetch_addr, // fetch
   input wire        cpu_start,      // start
   input wire [1:0]  clk_src_sel,    // clock
   input wire        bod_irq,        // bod irq
   input wire [1:0]  bod_irq_sel,    // irq level
   input wire        bod_rst_en,     // enable
   input wire [1:0]  prot_level,     // level
   input wire        isp_enter,      // pin entry
   input wire        isp_cmd_grant,  // isp grant
   input wire        iap_cmd_grant,  // iap grant
   input wire        swd_en,         // debug on
   input wire        jtag_bscan_en,  // scan mode
   input wire        jtag_pin_route  // scan pins
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   a_pin_reset: assert property (!reset_pin_in |-> !chip_rst_n)
      else $error("pin low but chip reset released");
   a_wdt_reset: assert property (wdt_rst_req |-> !chip_rst_n)
      else $error("watchdog request but chip reset released");
   a_start_pulse: assert property (cpu_start |-> chip_rst_n &&
      cpu_fetch_addr == `RBAC_RESET_VECTOR && clk_src_sel == `RBAC_CLK_FRO ##1 !cpu_start)
      else $error("bad start pulse");
   a_debug_in_reset: assert property (!chip_rst_n |-> !swd_en)
      else $error("debug enabled in reset");
   a_scan_select: assert property ($stable(reset_pin_in)[*3] |->
      jtag_bscan_en == !reset_pin_in && jtag_pin_route == jtag_bscan_en)
      else $error("scan mode does not follow pin");
   a_bod_quiet: assert property (vdd_code >= `RBAC_BOD_IRQ_LVL3 |=> !bod_irq)
      else $error("brownout irq above all levels");
   a_bod_force: assert property (bod_rst_en && vdd_code < `RBAC_BOD_RST_LVL0
      |=> !chip_rst_n) else $error("brownout reset missing");
   a_cfg_write: assert property (bod_cfg_we |=> bod_irq_sel == $past(bod_irq_sel_in)
      && bod_rst_en == $past(bod_rst_en_in)) else $error("brownout settings not taken");
   a_level_three: assert property (prot_level == `RBAC_LVL_THREE |->
      !isp_cmd_grant && !isp_enter) else $error("programming open at level three");
   a_protect_debug: assert property (prot_level != `RBAC_LVL_NONE |-> !swd_en)
      else $error("debug open under protection");
   a_iap_free: assert property (iap_cmd_valid && chip_rst_n |-> iap_cmd_grant)
      else $error("firmware command refused");
   c_start: cover property (cpu_start);
   c_bod_irq: cover property (bod_irq);
   c_level_three: cover property (prot_level == `RBAC_LVL_THREE);
endmodule
bind rbac_top rbac_top_chk u_chk (.clk_sys, .rst_n, .reset_pin_in, .wdt_rst_req, .vdd_code,
   .bod_cfg_we, .bod_irq_sel_in, .bod_rst_en_in, .iap_cmd_valid, .chip_rst_n, .cpu_fetch_addr,
   .cpu_start, .clk_src_sel, .bod_irq, .bod_irq_sel, .bod_rst_en, .prot_level, .isp_enter,
   .isp_cmd_grant, .iap_cmd_grant, .swd_en, .jtag_bscan_en, .jtag_pin_route);

// ===== tb.sv
// self-checking bench for the reset, brownout and access control block
// assumes rbac_top, the external party model and the bound checker
`timescale 1ns/100ps
`include "rbac_defs.vh"
module tb;
   typedef struct {logic [31:0] word; logic [2:0] cls; logic [4:0] sec;
      logic [1:0] lvl; logic grant;} rbac_row_t;
   logic        clk_sys = 1'b0, rst_n = 1'b0, wdt_rst_req = 1'b0, vdd_usable = 1'b1;
   logic        low_power_osc_ready = 1'b1, ext_clk_ready = 1'b0, clk_sel_we = 1'b0, bod_cfg_we = 1'b0;
   logic        bod_rst_en_in = 1'b0, isp_pin_req = 1'b1, isp_cmd_valid = 1'b1;
   logic        iap_cmd_valid = 1'b0, slow = 1'b0, pin_low = 1'b0;
   logic [1:0]  clk_sel_wdata = 2'h0, bod_irq_sel_in = 2'h0, bod_rst_sel_in = 2'h0;
   logic [1:0]  dbg_watch_req = 2'h3;
   logic [2:0]  isp_cmd_class = 3'h0;
   logic [3:0]  dbg_bkpt_req = 4'h0;
   logic [4:0]  isp_sector = 5'h00;
   logic [7:0]  vdd_code = 8'h90;
   logic [31:0] prot_word_in = 32'h0;
   wire         reset_pin_in, fro_ready, flash_init_done, chip_rst_n, fro_en, flash_init_req;
   wire         cpu_start, bod_irq, bod_status, bod_rst_en, isp_pin_dis, isp_enter, swd_en;
   wire         isp_cmd_grant, iap_cmd_grant, jtag_bscan_en, jtag_pin_route, jtag_cpu_dbg;
   wire         rst_cause_pin, rst_cause_bod, rst_cause_wdt;
   wire [1:0]   clk_src_sel, bod_irq_sel, bod_rst_sel, prot_level, dbg_watch_en;
   wire [3:0]   dbg_bkpt_en;
   wire [31:0]  cpu_fetch_addr;
   int          errors = 0, num_checks = 0;
   rbac_row_t rows [10] = '{
      '{32'h0,               `RBAC_CMD_ERASE_ALL, 5'h00, `RBAC_LVL_NONE,  1'b1},
      '{`RBAC_PROT_PAT_ONE,   `RBAC_CMD_WRITE,     5'h00, `RBAC_LVL_ONE,   1'b0},
      '{`RBAC_PROT_PAT_ONE,   `RBAC_CMD_ERASE_SEC, 5'h1f, `RBAC_LVL_ONE,   1'b1},
      '{`RBAC_PROT_PAT_ONE,   `RBAC_CMD_GO,        5'h00, `RBAC_LVL_ONE,   1'b1},
      '{`RBAC_PROT_PAT_ONE,   `RBAC_CMD_ERASE_ALL, 5'h03, `RBAC_LVL_ONE,   1'b0},
      '{`RBAC_PROT_PAT_TWO,   `RBAC_CMD_ERASE_ALL, 5'h00, `RBAC_LVL_TWO,   1'b1},
      '{`RBAC_PROT_PAT_TWO,   `RBAC_CMD_ERASE_SEC, 5'h02, `RBAC_LVL_TWO,   1'b0},
      '{`RBAC_PROT_PAT_TWO,   `RBAC_CMD_READ,      5'h00, `RBAC_LVL_TWO,   1'b0},
      '{`RBAC_PROT_PAT_THREE, `RBAC_CMD_INFO,      5'h00, `RBAC_LVL_THREE, 1'b0},
      '{`RBAC_PROT_PAT_NOPIN, `RBAC_CMD_READ,      5'h00, `RBAC_LVL_NONE,  1'b1}};
   rbac_top DUT (.clk_sys, .rst_n, .reset_pin_in, .wdt_rst_req, .vdd_usable, .vdd_code,
      .fro_ready, .flash_init_done, .prot_word_in, .low_power_osc_ready, .ext_clk_ready, .clk_sel_we,
      .clk_sel_wdata, .bod_cfg_we, .bod_irq_sel_in, .bod_rst_sel_in, .bod_rst_en_in, .isp_pin_req,
      .isp_cmd_valid, .isp_cmd_class, .isp_sector, .iap_cmd_valid, .dbg_bkpt_req, .dbg_watch_req,
      .chip_rst_n, .fro_en, .flash_init_req, .cpu_fetch_addr, .cpu_start, .clk_src_sel, .bod_irq,
      .bod_status, .bod_irq_sel, .bod_rst_sel, .bod_rst_en, .prot_level, .isp_pin_dis, .isp_enter,
      .isp_cmd_grant, .iap_cmd_grant, .swd_en, .jtag_bscan_en, .jtag_pin_route, .jtag_cpu_dbg,
      .dbg_bkpt_en, .dbg_watch_en, .rst_cause_pin, .rst_cause_wdt, .rst_cause_bod);
   rbac_ext_model u_ext (.clk_sys, .rst_n, .slow, .pin_low, .fro_en, .flash_init_req,
      .fro_ready, .flash_init_done, .reset_pin_in);
   always #25 clk_sys = ~clk_sys;
   task automatic chk_bit(input logic got, input logic exp, input string what);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: %s got %b want %b", $time, what, got, exp);
      end
   endtask
   task automatic chk_vec(input logic [31:0] got, input logic [31:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   // bounded wait for the start pulse, then the state the processor starts in
   task automatic wait_start;
      int n = 0;
      do begin
         tick(1);
         n++;
      end while (cpu_start !== 1'b1 && n < 200);
      chk_bit(cpu_start, 1'b1, "start");
      chk_bit(chip_rst_n, 1'b1, "released");
      chk_vec(cpu_fetch_addr, 32'h0, "fetch address");
      chk_vec(clk_src_sel, `RBAC_CLK_FRO, "clock source");
      chk_bit(fro_en, 1'b1, "osc on");
      chk_bit(flash_init_req, 1'b0, "flash idle");
      if (cpu_start !== 1'b1)
         report_and_stop;
   endtask
   task automatic reboot(input logic [31:0] w);
      @(posedge clk_sys);
      wdt_rst_req <= 1'b1;
      prot_word_in <= w;
      slow <= ~slow;
      @(posedge clk_sys);
      wdt_rst_req <= 1'b0;
      wait_start;
   endtask
   initial begin
      tick(16);
      chk_bit(chip_rst_n, 1'b0, "reset out");
      chk_bit(swd_en, 1'b0, "debug in reset");
      chk_vec(bod_irq_sel, 2'h0, "irq level");
      chk_bit(bod_rst_en, 1'b0, "bod enable");
      @(posedge clk_sys);
      rst_n <= 1'b1;
      wait_start;
      foreach (rows[i]) begin
         reboot(rows[i].word);
         @(posedge clk_sys);
         isp_cmd_class <= rows[i].cls;
         isp_sector <= rows[i].sec;
         iap_cmd_valid <= i[0];
         dbg_bkpt_req <= i[3:0];
         tick(2);
         chk_vec(prot_level, rows[i].lvl, "level");
         chk_bit(isp_cmd_grant, rows[i].grant, "isp grant");
         chk_bit(iap_cmd_grant, i[0], "iap grant");
         chk_bit(swd_en, rows[i].lvl === 2'h0, "debug");
         chk_bit(isp_pin_dis, rows[i].word === `RBAC_PROT_PAT_NOPIN, "pin entry");
         chk_vec(dbg_bkpt_en, rows[i].lvl === 2'h0 ? i[3:0] : 4'h0, "bkpt");
         chk_vec(dbg_watch_en, rows[i].lvl === 2'h0 ? 2'h3 : 2'h0, "watch");
         chk_bit(rst_cause_wdt, 1'b1, "wdt cause");
         chk_bit(isp_enter, rows[i].lvl !== `RBAC_LVL_THREE &&
            rows[i].word !== `RBAC_PROT_PAT_NOPIN, "isp entry");
      end
      // second write asks for an external clock that is not ready
      @(posedge clk_sys);
      clk_sel_we <= 1'b1;
      clk_sel_wdata <= `RBAC_CLK_LOW_POWER_OSC;
      @(posedge clk_sys);
      clk_sel_wdata <= `RBAC_CLK_EXT;
      @(posedge clk_sys);
      clk_sel_we <= 1'b0;
      pin_low <= 1'b1;
      #1;
      chk_vec(clk_src_sel, `RBAC_CLK_LOW_POWER_OSC, "clock pick");
      @(posedge clk_sys);
      pin_low <= 1'b0;
      #1;
      chk_bit(chip_rst_n, 1'b0, "pin pulse");
      wait_start;
      chk_bit(rst_cause_pin, 1'b1, "pin cause");
      @(posedge clk_sys);
      pin_low <= 1'b1;
      tick(5);
      chk_bit(jtag_bscan_en, 1'b1, "scan mode");
      chk_bit(jtag_pin_route, 1'b1, "scan pins");
      chk_bit(jtag_cpu_dbg, 1'b0, "scan debug");
      chk_bit(swd_en, 1'b0, "debug off");
      @(posedge clk_sys);
      pin_low <= 1'b0;
      wait_start;
      chk_bit(jtag_bscan_en, 1'b0, "debug mode");
      @(posedge clk_sys);
      bod_cfg_we <= 1'b1;
      bod_irq_sel_in <= 2'h3;
      bod_rst_sel_in <= 2'h3;
      @(posedge clk_sys);
      bod_cfg_we <= 1'b0;
      vdd_code <= `RBAC_BOD_IRQ_LVL3 - 8'h01;
      tick(2);
      chk_bit(bod_irq, 1'b1, "bod irq");
      chk_bit(bod_status, 1'b1, "bod status");
      chk_bit(chip_rst_n, 1'b1, "reset disabled");
      chk_vec(bod_rst_sel, 2'h3, "reset level");
      @(posedge clk_sys);
      bod_cfg_we <= 1'b1;
      bod_rst_en_in <= 1'b1;
      vdd_code <= `RBAC_BOD_RST_LVL3;
      @(posedge clk_sys);
      bod_cfg_we <= 1'b0;
      tick(2);
      chk_bit(chip_rst_n, 1'b1, "at level");
      @(posedge clk_sys);
      vdd_code <= `RBAC_BOD_RST_LVL3 - 8'h01;
      tick(2);
      chk_bit(chip_rst_n, 1'b0, "bod reset");
      @(posedge clk_sys);
      vdd_code <= 8'h40;
      tick(2);
      vdd_code <= 8'h90;
      wait_start;
      chk_bit(rst_cause_bod, 1'b1, "bod cause");
      chk_bit(bod_rst_en, 1'b1, "settings kept");
      chk_bit(bod_irq, 1'b0, "bod clear");
      @(posedge clk_sys);
      vdd_usable <= 1'b0;
      tick(3);
      chk_bit(chip_rst_n, 1'b0, "supply low");
      @(posedge clk_sys);
      vdd_usable <= 1'b1;
      wait_start;
      report_and_stop;
   end
endmodule
